// file: rtl/self_program_flash_control.sv
// Module: self-programming control for on-chip program flash
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module self_program_flash_control
    import spc_pkg::*;
#(
    parameter int unsigned PROG_CYC   = ProgCyc,
    parameter int unsigned RWW_LIMIT  = 16'h3800
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // Core instruction side
    input  wire logic        storeInstr,
    input  wire logic        loadInstr,
    input  wire logic [15:0] zPtr,
    input  wire logic [7:0]  gpr0,
    input  wire logic [7:0]  gpr1,
    input  wire logic        globalIrqEn,
    input  wire logic        execInBoot,
    input  wire logic        vectorsInBoot,
    input  wire logic        loadFromBoot,
    input  wire logic        chipErase,
    output logic      [7:0]  loadData,
    output logic             loadDataValid,
    output logic             storeReadyIrq,
    output logic             coreHalt,
    output logic             rwwReadBlock,
    output logic             irqDisable,
    output logic             appLoadBlock,
    // Flash array side
    output logic             bufWordWr,
    output logic      [5:0]  bufWordAddr,
    output logic      [15:0] bufWordData,
    output logic             bufClear,
    output logic             pageEraseGo,
    output logic             pageWriteGo,
    output logic      [7:0]  pageAddr,
    // Lock status
    output logic      [1:0]  memLockMode
);
    initial
    begin
        // Limit is a word address; the pointer only reaches 14 bits of words
        if (RWW_LIMIT > 32'h4000) $error("RWW_LIMIT beyond the word space");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    spc_cmd_if tmrIf ();
    spc_prog_timer #(.PROG_CYC(PROG_CYC)) u_timer (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .cmd     (tmrIf)
    );

    op_state_e   state_r;
    logic [4:0]  cmd_r;
    logic [2:0]  win_r;
    logic        irqEn_r;
    logic        busy_r;
    logic        nrwwOp_r;
    logic        filling_r;
    logic [7:0]  lock_r;
    logic [7:0]  fuseL_r;
    logic [7:0]  fuseH_r;
    logic        rdValid_r;
    logic [7:0]  rdData_r;
    logic [7:0]  ldData_r;
    logic        ldValid_r;
    logic        opWasLock_r;

    // Maps a byte pointer to its page index
    function automatic logic [7:0] page_of(input logic [15:0] z);
        page_of = z[PageHi:PageLo];
    endfunction

    // Application lock mode: 1..4 from the two app lock bits
    function automatic logic [2:0] app_mode(input logic [7:0] lk);
        case ({lk[LockAppHi], lk[LockAppLo]})
            2'b11:   app_mode = 3'd1;
            2'b10:   app_mode = 3'd2;
            2'b00:   app_mode = 3'd3;
            default: app_mode = 3'd4;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic       ctlWr;
    logic       cmdValid;
    logic       storeGo;
    logic       inApp;
    logic       inNrww;
    logic [2:0] appMode;

    assign ctlWr    = regWr && (regAddr == AddrCtl);
    assign cmdValid = (regWdata[4:0] == CmdReen) || (regWdata[4:0] == CmdLock) ||
                      (regWdata[4:0] == CmdWrite) || (regWdata[4:0] == CmdErase) ||
                      (regWdata[4:0] == CmdFill);
    assign storeGo  = (state_r == OP_ARMED) && storeInstr;
    // Pointer holds a byte address; word address is z[14:1], bit 15 dropped
    assign inNrww   = {1'b0, zPtr[14:0]} >= 16'(RWW_LIMIT << 1);
    assign inApp    = !inNrww;
    assign appMode  = app_mode(lock_r);

    // ----------------------------------------------------------------
    // Sequencer: arm window, start and completion
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r     <= OP_IDLE;
            cmd_r       <= 5'h00;
            win_r       <= 3'h0;
            opWasLock_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                OP_IDLE:
                begin
                    if (ctlWr && cmdValid)
                    begin
                        state_r <= OP_ARMED;
                        cmd_r   <= regWdata[4:0];
                        win_r   <= 3'(ArmWindowCyc - 1);
                    end
                end
                OP_ARMED:
                begin
                    if (storeGo && ((cmd_r == CmdErase) || (cmd_r == CmdWrite)) &&
                        !(inApp && (appMode == 3'd2 || appMode == 3'd3)))
                    begin
                        state_r     <= OP_BUSY;
                        opWasLock_r <= 1'b0;
                    end
                    else if (storeGo && cmd_r == CmdLock)
                    begin
                        state_r     <= OP_BUSY;
                        opWasLock_r <= 1'b1;
                    end
                    else if (storeGo || win_r == 3'h0)
                    begin
                        state_r <= OP_IDLE;
                        cmd_r   <= 5'h00;
                    end
                    else
                        win_r <= win_r - 3'h1;
                end
                OP_BUSY:
                begin
                    if (tmrIf.done)
                    begin
                        state_r <= OP_IDLE;
                        cmd_r   <= 5'h00;
                    end
                end
                default:
                    state_r <= OP_IDLE;
            endcase
        end
    end

    assign tmrIf.start = (state_r == OP_ARMED) && (state_r != OP_BUSY) && storeGo &&
                         ((cmd_r == CmdLock) || (((cmd_r == CmdErase) || (cmd_r == CmdWrite))
                         && !(inApp && (appMode == 3'd2 || appMode == 3'd3))));

    // ----------------------------------------------------------------
    // Array strobes
    // ----------------------------------------------------------------
    logic startEw;
    assign startEw     = tmrIf.start && (cmd_r != CmdLock);
    assign pageEraseGo = startEw && (cmd_r == CmdErase);
    assign pageWriteGo = startEw && (cmd_r == CmdWrite);
    assign pageAddr    = page_of(zPtr);
    assign bufWordWr   = storeGo && (cmd_r == CmdFill);
    assign bufWordAddr = zPtr[WordHi:WordLo];
    assign bufWordData = {gpr1, gpr0};
    assign bufClear    = ctlWr && regWdata[CtlReenBit] && filling_r;

    // ----------------------------------------------------------------
    // Busy, fill tracking and halt
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_r    <= 1'b0;
            nrwwOp_r  <= 1'b0;
            filling_r <= 1'b0;
        end
        else
        begin
            if (startEw && inApp)
                busy_r <= 1'b1;
            else if (bufWordWr)
                busy_r <= 1'b0;
            else if (storeGo && cmd_r == CmdReen)
                busy_r <= 1'b0;
            if (startEw)
                nrwwOp_r <= inNrww;
            if (bufWordWr)
                filling_r <= 1'b1;
            else if (bufClear || pageWriteGo)
                filling_r <= 1'b0;
        end
    end

    assign rwwReadBlock = busy_r;
    assign coreHalt     = (state_r == OP_BUSY) && !opWasLock_r && nrwwOp_r;

    // ----------------------------------------------------------------
    // Lock bits and fuses
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_r  <= LockReset;
            fuseL_r <= FuseLReset;
            fuseH_r <= FuseHReset;
        end
        else if (chipErase)
            lock_r <= LockReset;
        else if (tmrIf.start && cmd_r == CmdLock)
            lock_r <= lock_r & {2'b11, gpr0[5:2], 2'b11};
    end

    assign memLockMode = {lock_r[LockMemHi], lock_r[LockMemLo]};
    assign appLoadBlock = execInBoot && loadFromBoot && inApp &&
                          (appMode == 3'd3 || appMode == 3'd4);
    assign irqDisable  = vectorsInBoot && !execInBoot &&
                         (appMode == 3'd3 || appMode == 3'd4);

    // ----------------------------------------------------------------
    // Lock and fuse readback through load instruction
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ldData_r  <= 8'h00;
            ldValid_r <= 1'b0;
        end
        else
        begin
            ldValid_r <= loadInstr && (state_r == OP_ARMED) && (cmd_r == CmdLock) &&
                         (win_r >= 3'(ArmWindowCyc - LoadWindowCyc));
            ldData_r  <= zPtr[0] ? fuseL_r : lock_r;
        end
    end
    assign loadData      = ldData_r;
    assign loadDataValid = ldValid_r;

    // ----------------------------------------------------------------
    // Control register and register read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            irqEn_r <= CtlReset[CtlIrqEnBit];
        else if (ctlWr)
            irqEn_r <= regWdata[CtlIrqEnBit];
    end

    logic [7:0] ctlView;
    logic       storeEn;
    assign storeEn = state_r != OP_IDLE;
    assign ctlView = {irqEn_r, busy_r, 1'b0, cmd_r[4:1], storeEn};

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_r <= 8'h00;
        else if (regRd)
        begin
            case (regAddr)
                AddrCtl:   rdData_r <= ctlView;
                AddrLock:  rdData_r <= lock_r;
                AddrFuseL: rdData_r <= fuseL_r;
                AddrFuseH: rdData_r <= fuseH_r;
                AddrStat:  rdData_r <= {5'h00, appMode};
                default:   rdData_r <= 8'h00;
            endcase
        end
    end
    assign regRdata = rdData_r;

    // Ready interrupt is a level; core clears it by arming a new command
    assign storeReadyIrq = irqEn_r && globalIrqEn && !storeEn;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        storeReadyIrq == (irqEn_r && globalIrqEn && state_r == OP_IDLE))
        else $error("ready interrupt wrong");
    arm_timeout_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctlWr && cmdValid && state_r == OP_IDLE) ##1 !storeInstr [*4] |=> state_r == OP_IDLE)
        else $error("arm window not four cycles");
    bad_cmd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctlWr && !cmdValid && state_r == OP_IDLE) |=> state_r == OP_IDLE)
        else $error("invalid pattern acted");
    busy_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (startEw && inApp) |=> rwwReadBlock)
        else $error("busy not set");
    busy_fill_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (bufWordWr && !startEw) |=> !rwwReadBlock)
        else $error("busy not cleared by fill");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $past(regRd && regAddr == AddrCtl) |-> !regRdata[5])
        else $error("reserved bit set");
    idle_store_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == OP_IDLE) |-> !(bufWordWr || pageEraseGo || pageWriteGo))
        else $error("store acted while disabled");
    app_refuse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (storeGo && inApp && (appMode == 3'd2 || appMode == 3'd3)) |->
        !(pageWriteGo || pageEraseGo))
        else $error("application write allowed");
    lock_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !chipErase |=> ((lock_r & ~$past(lock_r)) == 8'h00))
        else $error("lock bit unprogrammed");
    halt_busy_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        coreHalt |-> state_r == OP_BUSY)
        else $error("halt outside operation");

    erase_c: cover property (@(posedge ref_clk) disable iff (!arst_n) pageEraseGo);
    write_c: cover property (@(posedge ref_clk) disable iff (!arst_n) pageWriteGo);
    fill_c:  cover property (@(posedge ref_clk) disable iff (!arst_n) bufWordWr);
    lockrd_c: cover property (@(posedge ref_clk) disable iff (!arst_n) loadDataValid);
endmodule

// file: rtl/spc_pkg.sv
// Package: constants and types for the self-program flash control block
package spc_pkg;
    // Control register bit positions
    localparam int CtlEnBit      = 0;
    localparam int CtlEraseBit   = 1;
    localparam int CtlWriteBit   = 2;
    localparam int CtlLockBit    = 3;
    localparam int CtlReenBit    = 4;
    localparam int CtlBusyBit    = 6;
    localparam int CtlIrqEnBit   = 7;
    localparam logic [7:0] CtlReset = 8'h00;
    // Valid five-bit command patterns
    localparam logic [4:0] CmdReen  = 5'h11;
    localparam logic [4:0] CmdLock  = 5'h09;
    localparam logic [4:0] CmdWrite = 5'h05;
    localparam logic [4:0] CmdErase = 5'h03;
    localparam logic [4:0] CmdFill  = 5'h01;
    // Register addresses (word index on the plain port)
    localparam logic [3:0] AddrCtl   = 4'h0;
    localparam logic [3:0] AddrLock  = 4'h1;
    localparam logic [3:0] AddrFuseL = 4'h2;
    localparam logic [3:0] AddrFuseH = 4'h3;
    localparam logic [3:0] AddrStat  = 4'h4;
    // Lock byte layout and reset
    localparam int LockMemLo  = 0;
    localparam int LockMemHi  = 1;
    localparam int LockAppLo  = 2;
    localparam int LockAppHi  = 3;
    localparam logic [7:0] LockReset  = 8'hff;
    localparam logic [7:0] FuseLReset = 8'he1;
    localparam logic [7:0] FuseHReset = 8'h99;
    // Timing
    localparam int ArmWindowCyc  = 4;
    localparam int LoadWindowCyc = 3;
    localparam int ClkMhz        = 20;
    localparam int ProgTimeUs    = 3700;
    localparam int ProgCyc       = ProgTimeUs * ClkMhz;
    // Pointer fields
    localparam int PageHi = 14;
    localparam int PageLo = 7;
    localparam int WordHi = 6;
    localparam int WordLo = 1;
    typedef enum logic [2:0] {
        OP_IDLE  = 3'b000,
        OP_ARMED = 3'b001,
        OP_BUSY  = 3'b010
    } op_state_e;
endpackage

// file: rtl/spc_cmd_if.sv
// Interface: decoded command strobes between the sequencer and the timer
`timescale 1ns/100ps
interface spc_cmd_if;
    logic start;
    logic done;
    modport seq (output start, input done);
    modport tmr (input start, output done);
endinterface

// file: rtl/spc_prog_timer.sv
// Module: programming-time counter for erase, write and lock updates
`timescale 1ns/100ps
module spc_prog_timer
    import spc_pkg::*;
#(
    parameter int unsigned PROG_CYC = ProgCyc
)(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Command side
    spc_cmd_if.tmr    cmd
);
    initial
    begin
        if (PROG_CYC < 1) $error("PROG_CYC must be at least one");
    end

    logic [31:0] cnt_r;
    logic        run_r;

    // Counts down the programming time, pulses done at the end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 32'h0;
            run_r <= 1'b0;
        end
        else if (cmd.start)
        begin
            cnt_r <= 32'(PROG_CYC - 1);
            run_r <= 1'b1;
        end
        else if (run_r)
        begin
            if (cnt_r == 32'h0)
                run_r <= 1'b0;
            else
                cnt_r <= cnt_r - 32'h1;
        end
    end

    assign cmd.done = run_r && (cnt_r == 32'h0);
endmodule

// file: tb/core_model.sv
// Core model: issues program-store and program-load pulses with their operands
`timescale 1ns/100ps
module core_model (
    // Clock
    input  wire logic ref_clk,
    // Instruction side
    output logic        storeInstr,
    output logic        loadInstr,
    output logic [15:0] zPtr,
    output logic [7:0]  gpr0,
    output logic [7:0]  gpr1
);
    // Idle at time zero
    initial
    begin
        {storeInstr, loadInstr, zPtr, gpr0, gpr1} = '0;
    end

    // Raise one instruction right after an edge, operands beside it
    task automatic start(input logic ld, input logic [15:0] z, input logic [15:0] d);
        zPtr <= z;
        {gpr1, gpr0} <= d;
        if (ld)
            loadInstr <= 1'b1;
        else
            storeInstr <= 1'b1;
    endtask

    // Drop it after the sampling edge; operands flip so stale values never help
    task automatic stop;
        @(posedge ref_clk);
        storeInstr <= 1'b0;
        loadInstr  <= 1'b0;
        zPtr       <= ~zPtr;
        gpr0       <= ~gpr0;
        gpr1       <= ~gpr1;
    endtask
endmodule

// file: tb/testbench.sv
// Testbench: self-checking run of the self-program flash control block
`timescale 1ns/100ps
module testbench;
    import spc_pkg::*;
    logic        ref_clk, arst_n, regWr, regRd, globalIrqEn, execInBoot;
    logic        vectorsInBoot, loadFromBoot, chipErase, storeInstr, loadInstr;
    logic        loadDataValid, storeReadyIrq, coreHalt, rwwReadBlock, irqDisable;
    logic        appLoadBlock, bufWordWr, bufClear, pageEraseGo, pageWriteGo;
    logic [3:0]  regAddr;
    logic [7:0]  regWdata, regRdata, gpr0, gpr1, loadData, pageAddr, d;
    logic [15:0] zPtr, bufWordData;
    logic [5:0]  bufWordAddr;
    logic [1:0]  memLockMode, snap;
    int          failures, n_tests;

    // Short programming time keeps the run brief
    self_program_flash_control #(.PROG_CYC(8)) i_self_program_flash_control (
        .ref_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .storeInstr, .loadInstr, .zPtr, .gpr0, .gpr1, .globalIrqEn, .execInBoot,
        .vectorsInBoot, .loadFromBoot, .chipErase, .loadData, .loadDataValid,
        .storeReadyIrq, .coreHalt, .rwwReadBlock, .irqDisable, .appLoadBlock,
        .bufWordWr, .bufWordAddr, .bufWordData, .bufClear, .pageEraseGo,
        .pageWriteGo, .pageAddr, .memLockMode);
    core_model i_core_model (.ref_clk, .storeInstr, .loadInstr, .zPtr, .gpr0, .gpr1);

    // Clock at 20 MHz
    always #25 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Register write: one cycle of strobe, entered and left at a rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // Register read: data sampled mid-cycle after the strobe edge, halt and busy too
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        v = regRdata;
        snap = {coreHalt, rwwReadBlock};
        @(posedge ref_clk);
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 40 && d[0] !== 1'b0; n++)
            rd(AddrCtl, d);
    endtask

    task automatic t_reset_irq;
        rd(AddrCtl, d);
        chk("ctl reset", CtlReset, d);
        rd(AddrLock, d);
        chk("lock reset", LockReset, d);
        chk("mem lock mode", 2'b11, memLockMode);
        globalIrqEn <= 1'b1;
        wr(AddrCtl, 8'ha7);
        rd(AddrCtl, d);
        chk("ctl odd pattern", 8'h80, d);
        chk("irq ready", 1, storeReadyIrq);
        wr(AddrCtl, 8'h81);
        #1 chk("irq armed", 0, storeReadyIrq);
        repeat (6) @(posedge ref_clk);
        #1 chk("irq after timeout", 1, storeReadyIrq);
        @(posedge ref_clk);
        globalIrqEn <= 1'b0;
        #1 chk("irq global off", 0, storeReadyIrq);
        @(posedge ref_clk);
        wr(AddrCtl, 8'h00);
        // Let an edge pass so the next write never re-raises the strobe in one step
        @(posedge ref_clk);
        $display("done reset and irq");
    endtask

    task automatic t_fill;
        wr(AddrCtl, CmdFill);
        i_core_model.start(1'b0, 16'h807f, 16'ha55a);
        #1 chk("fill strobe", 1, bufWordWr);
        chk("fill word", 6'h3f, bufWordAddr);
        chk("fill data", 16'ha55a, bufWordData);
        i_core_model.stop;
        rd(AddrCtl, d);
        chk("enable after fill", 0, d[0]);
        wr(AddrCtl, CmdWrite);
        repeat (5) @(posedge ref_clk);
        i_core_model.start(1'b0, 16'h0100, 16'h0);
        #1 chk("late write go", 0, pageWriteGo);
        i_core_model.stop;
        rd(AddrCtl, d);
        chk("late write ctl", 0, d[4:0]);
        // Re-enable written while the buffer holds data aborts it; a second one finds it empty
        for (int a = 0; a < 2; a++)
        begin
            regAddr  <= AddrCtl;
            regWdata <= 8'(CmdReen);
            regWr    <= 1'b1;
            #1 chk("fill abort", a == 0, bufClear);
            @(posedge ref_clk);
            regWr <= 1'b0;
            d = 8'h01;
            wait_idle;
        end
        $display("done fill and timeout");
    endtask

    task automatic t_prog;
        logic [15:0] z;
        for (int k = 0; k < 3; k++)
        begin
            z = (k == 2) ? 16'hf080 : 16'h8100;
            wr(AddrCtl, (k == 1) ? CmdWrite : CmdErase);
            i_core_model.start(1'b0, z, 16'h0);
            #1 chk("erase go", k != 1, pageEraseGo);
            chk("write go", k == 1, pageWriteGo);
            chk("page address", z[14:7], pageAddr);
            i_core_model.stop;
            rd(AddrCtl, d);
            chk("enable held busy", 1, d[0]);
            chk("busy bit", k < 2, d[CtlBusyBit]);
            chk("halt and block", {k == 2, k < 2}, snap);
            wait_idle;
            chk("command cleared", 0, d[2:0]);
            if (k < 2)
            begin
                wr(AddrCtl, (k == 0) ? CmdFill : CmdReen);
                i_core_model.start(1'b0, 16'h0002, 16'h1234);
                i_core_model.stop;
                rd(AddrCtl, d);
                chk("busy released", 0, {d[CtlBusyBit], snap[0]});
            end
        end
        $display("done programming");
    endtask

    task automatic t_lock;
        for (int b = 0; b < 2; b++)
        begin
            wr(AddrCtl, CmdLock);
            i_core_model.start(1'b1, 16'(b), 16'h0);
            i_core_model.stop;
            @(negedge ref_clk);
            chk("load valid", 1, loadDataValid);
            chk("load byte", b ? FuseLReset : LockReset, loadData);
            @(posedge ref_clk);
            // Arm window must run out before the next command is taken
            d = 8'h01;
            wait_idle;
        end
        wr(AddrCtl, CmdLock);
        i_core_model.start(1'b0, 16'h1234, 16'hffc3);
        i_core_model.stop;
        d = 8'h01;
        wait_idle;
        rd(AddrLock, d);
        chk("lock bits set", 8'hc3, d);
        chk("mem lock kept", 2'b11, memLockMode);
        rd(AddrStat, d);
        chk("app lock mode", 3, d);
        wr(AddrCtl, CmdErase);
        i_core_model.start(1'b0, 16'h0100, 16'h0);
        #1 chk("app erase refused", 0, pageEraseGo);
        i_core_model.stop;
        loadFromBoot <= 1'b1;
        vectorsInBoot <= 1'b1;
        execInBoot <= 1'b1;
        i_core_model.start(1'b1, 16'h0100, 16'h0);
        #1 chk("boot load blocked", 1, appLoadBlock);
        chk("boot irq kept", 0, irqDisable);
        i_core_model.stop;
        // Code now runs from the application section
        execInBoot <= 1'b0;
        chipErase <= 1'b1;
        #1 chk("app irq off", 1, irqDisable);
        @(posedge ref_clk);
        chipErase <= 1'b0;
        rd(AddrLock, d);
        chk("lock after erase", LockReset, d);
        $display("done lock bits");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence: reset held for 16 cycles, then each scenario in turn
    initial
    begin
        {ref_clk, arst_n, regWr, regRd, globalIrqEn, execInBoot} = '0;
        {vectorsInBoot, loadFromBoot, chipErase, regAddr, regWdata} = '0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset_irq;
        t_fill;
        t_prog;
        t_lock;
        summarize;
    end

    // Watchdog well beyond the few hundred cycles the scenarios need
    initial
    begin
        #150000;
        failures++;
        summarize;
    end
endmodule
